// ==== core/mhb_device.sv ====
// device end: frames host read and write cycles on the multiplexed bus
//
// Notes on behaviour
// - separate strobes: read spans read strobe with select
// - host moves select only with read/write strobe
// - direction mode: enable with select and read starts read
// - host moves select only with enable strobe
// - separate strobes: write spans write strobe with select
// - direction mode: enable with select and write starts write
// - strap picks separate strobes or direction plus enable
// - straps set polarity of latch, select, read, write
// - strap decides if latches need chip select
// - low and high latch phases in either order
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`include "mhb_map.svh"
module mhb_device (
  input wire logic clk,
  input wire logic rstn,
  mhb_bus_if.device bus,
  input wire mhb_pkg::mhb_strap_t strap_in,
  input wire logic [15:0] read_data,
  output logic [15:0] cycle_addr,
  output logic [15:0] write_data,
  output logic read_start,
  output logic write_start,
  output logic write_done,
  output mhb_pkg::mhb_cycle_t cycle_state,
  output logic select_violation
);
  // ----------------------------------------
  // strap capture after reset release
  // ----------------------------------------
  mhb_pkg::mhb_strap_t strap;
  logic strap_taken;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      strap <= '0;
      strap_taken <= 1'b0;
    end
    else if (!strap_taken)
    begin
      strap <= strap_in;
      strap_taken <= 1'b1;
    end
  end

  // ----------------------------------------
  // polarity decode
  // ----------------------------------------
  logic cs_act;
  logic ale_lo_act;
  logic ale_hi_act;
  logic rd_act;
  logic wr_act;
  logic read_req;
  logic write_req;
  logic strobe_act;
  logic [4:0] ctrl_pin;
  logic [4:0] ctrl_pol;
  logic [4:0] ctrl_act;
  assign ctrl_pin = {bus.chip_select, bus.low_addr_latch_strobe, bus.high_addr_latch_strobe, bus.read_dir,
                     bus.write_transfer_enable_strobe};
  assign ctrl_pol = {strap.cs_pol_high, strap.ale_pol_high, strap.ale_pol_high, strap.rd_pol_high,
                     strap.wr_pol_high};
  // each control line is active when it matches its strap polarity
  for (genvar i = 0; i < 5; i++)
  begin : g_pol
    assign ctrl_act[i] = ctrl_pin[i] ~^ ctrl_pol[i];
  end

  assign cs_act = ctrl_act[4];
  assign ale_lo_act = ctrl_act[3];
  assign ale_hi_act = ctrl_act[2];
  assign rd_act = ctrl_act[1];
  assign wr_act = ctrl_act[0];
  // in direction mode rd_act means direction shows read, wr_act means enable active
  assign strobe_act = strap.dir_enable_mode ? wr_act : (rd_act | wr_act);
  assign read_req = strap.dir_enable_mode ? (wr_act & rd_act) : rd_act;
  assign write_req = strap.dir_enable_mode ? (wr_act & !rd_act) : wr_act;
  // each transfer ends on the strobe that opened it
  logic read_end;
  logic write_end;
  assign read_end = strap.dir_enable_mode ? !wr_act : !rd_act;
  assign write_end = !wr_act;

  // ----------------------------------------
  // address latching, either phase order
  // ----------------------------------------
  logic ale_ok;
  assign ale_ok = strap_taken & (!strap.ale_cs_qualify | cs_act);
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cycle_addr <= 16'h0000;
    else if (ale_ok && ale_lo_act && ale_hi_act)
      cycle_addr <= bus.ad_in;
    else if (ale_ok && ale_lo_act)
      cycle_addr[7:0] <= bus.ad_in[7:0];
    else if (ale_ok && ale_hi_act)
      cycle_addr[15:8] <= bus.ad_in[7:0];
  end

  // ----------------------------------------
  // strobe and select history
  // ----------------------------------------
  // cycles start on the strobe's leading edge only, so a strobe that began
  // without select cannot become a cycle when select arrives late
  logic strobe_prev;
  logic cs_prev;
  logic strobe_rise;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      strobe_prev <= 1'b0;
      cs_prev <= 1'b0;
    end
    else
    begin
      strobe_prev <= strap_taken & strobe_act;
      cs_prev <= strap_taken & cs_act;
    end
  end
  assign strobe_rise = strobe_act & !strobe_prev;

  // ----------------------------------------
  // cycle framing
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cycle_state <= mhb_pkg::MHB_IDLE_CYC;
    else
    begin
      case (cycle_state)
        mhb_pkg::MHB_IDLE_CYC:
          if (strap_taken && cs_act && strobe_rise && read_req)
            cycle_state <= mhb_pkg::MHB_READ_CYC;
          else if (strap_taken && cs_act && strobe_rise && write_req)
            cycle_state <= mhb_pkg::MHB_WRITE_CYC;
        mhb_pkg::MHB_READ_CYC:
          if (read_end)
            cycle_state <= mhb_pkg::MHB_IDLE_CYC;
        mhb_pkg::MHB_WRITE_CYC:
          if (write_end)
            cycle_state <= mhb_pkg::MHB_IDLE_CYC;
        default:
          cycle_state <= mhb_pkg::MHB_IDLE_CYC;
      endcase
    end
  end

  // ----------------------------------------
  // start pulses
  // ----------------------------------------
  logic idle;
  assign idle = (cycle_state == mhb_pkg::MHB_IDLE_CYC);
  assign read_start = idle & strap_taken & cs_act & strobe_rise & read_req;
  assign write_start = idle & strap_taken & cs_act & strobe_rise & !read_req & write_req;

  // ----------------------------------------
  // write capture
  // ----------------------------------------
  // write data sampled each strobe cycle after the one that starts the write; last sample is the value in the final cycle before release
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      write_data <= 16'h0000;
    else if (cycle_state == mhb_pkg::MHB_WRITE_CYC && !write_end)
      write_data <= bus.ad_in;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      write_done <= 1'b0;
    else
      write_done <= (cycle_state == mhb_pkg::MHB_WRITE_CYC) & write_end;
  end

  // ----------------------------------------
  // select discipline
  // ----------------------------------------
  // select dropping or arriving mid-strobe is a host fault; flagged sticky until reset
  // select moving in the same cycle as the strobe edge is legal and not flagged
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      select_violation <= 1'b0;
    else if (strap_taken && !idle && strobe_act && !cs_act)
      select_violation <= 1'b1;
    else if (strap_taken && strobe_act && strobe_prev && (cs_act != cs_prev))
      select_violation <= 1'b1;
  end

  // ----------------------------------------
  // data drive only inside a selected read
  // ----------------------------------------
  logic [15:0] dout;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      dout <= 16'h0000;
    else
      dout <= read_data;
  end
  assign bus.ad_dev_out = dout;
  assign bus.ad_dev_oe = {16{(cycle_state == mhb_pkg::MHB_READ_CYC) & !read_end & cs_act}};
endmodule : mhb_device

// ==== core/mhb_map.svh ====
// constants for the multiplexed host bus cycle framing ends
`ifndef MHB_MAP_SVH
`define MHB_MAP_SVH
`define MHB_ADDR_W 16
`define MHB_DATA_W 16
`define MHB_CLK_PERIOD_NS 10
`define MHB_T_STROBE_ACTIVE_NS 32
`define MHB_T_STROBE_GAP_NS 13
`define MHB_T_ALE_WIDTH_NS 10
`define MHB_T_ALE_TO_STROBE_NS 5
`define MHB_T_RDWR_SETUP_NS 5
`define MHB_STROBE_ACTIVE_CYC ((`MHB_T_STROBE_ACTIVE_NS + `MHB_CLK_PERIOD_NS - 1) / `MHB_CLK_PERIOD_NS)
`define MHB_STROBE_GAP_CYC ((`MHB_T_STROBE_GAP_NS + `MHB_CLK_PERIOD_NS - 1) / `MHB_CLK_PERIOD_NS)
`define MHB_ALE_WIDTH_CYC ((`MHB_T_ALE_WIDTH_NS + `MHB_CLK_PERIOD_NS - 1) / `MHB_CLK_PERIOD_NS)
`define MHB_ALE_TO_STROBE_CYC ((`MHB_T_ALE_TO_STROBE_NS + `MHB_CLK_PERIOD_NS - 1) / `MHB_CLK_PERIOD_NS)
`define MHB_RDWR_SETUP_CYC ((`MHB_T_RDWR_SETUP_NS + `MHB_CLK_PERIOD_NS - 1) / `MHB_CLK_PERIOD_NS)
`endif

// ==== core/mhb_pkg.sv ====
// strap type shared by both ends of the multiplexed host bus, plus the device cycle state type
package mhb_pkg;
  typedef enum logic [1:0] {MHB_IDLE_CYC, MHB_READ_CYC, MHB_WRITE_CYC} mhb_cycle_t;
  typedef struct packed {
    logic dir_enable_mode;
    logic ale_pol_high;
    logic cs_pol_high;
    logic rd_pol_high;
    logic wr_pol_high;
    logic ale_cs_qualify;
  } mhb_strap_t;
endpackage : mhb_pkg

// ==== core/mhb_bus_if.sv ====
// pins of the multiplexed address/data host bus
`timescale 1ns/10ps
interface mhb_bus_if;
  logic chip_select;
  logic low_addr_latch_strobe;
  logic high_addr_latch_strobe;
  logic read_dir;
  logic write_transfer_enable_strobe;
  logic [15:0] ad_host_out;
  logic [15:0] ad_host_oe;
  logic [15:0] ad_dev_out;
  logic [15:0] ad_dev_oe;
  logic [15:0] ad_in;
  assign ad_in = (ad_dev_out & ad_dev_oe) | (ad_host_out & ad_host_oe);
  modport device (
    input chip_select, low_addr_latch_strobe, high_addr_latch_strobe, read_dir,
    input write_transfer_enable_strobe, ad_in,
    output ad_dev_out, ad_dev_oe
  );
  modport host (
    output chip_select, low_addr_latch_strobe, high_addr_latch_strobe, read_dir,
    output write_transfer_enable_strobe, ad_host_out, ad_host_oe,
    input ad_in
  );
endinterface : mhb_bus_if

// ==== core/mhb_host.sv ====
// host end: drives latch, select and strobes for one access per request
`timescale 1ns/10ps
`include "mhb_map.svh"
module mhb_host (
  input wire logic clk,
  input wire logic rstn,
  mhb_bus_if.host bus,
  input wire mhb_pkg::mhb_strap_t strap,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [15:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  output logic [15:0] rsp_rdata,
  output logic rsp_valid
);
  typedef enum logic [2:0] {MHB_H_IDLE, MHB_H_ALE_LO, MHB_H_ALE_HI, MHB_H_SETUP, MHB_H_STROBE,
                            MHB_H_GAP} mhb_hstate_t;
  localparam logic [3:0] ACT_CYC = 4'(`MHB_STROBE_ACTIVE_CYC);
  localparam logic [3:0] GAP_CYC = 4'(`MHB_STROBE_GAP_CYC);
  localparam logic [3:0] ALE_CYC = 4'(`MHB_ALE_WIDTH_CYC);
  localparam logic [3:0] SET_CYC = 4'(`MHB_ALE_TO_STROBE_CYC);
  mhb_hstate_t st;
  logic [3:0] cnt;
  logic wr;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic lo_first;

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= MHB_H_IDLE;
      cnt <= 4'h0;
      wr <= 1'b0;
      addr <= 16'h0000;
      wdata <= 16'h0000;
      rsp_rdata <= 16'h0000;
      rsp_valid <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (st)
        MHB_H_IDLE:
          if (req_valid)
          begin
            wr <= req_write;
            addr <= req_addr;
            wdata <= req_wdata;
            cnt <= ALE_CYC;
            st <= lo_first ? MHB_H_ALE_LO : MHB_H_ALE_HI;
          end
        MHB_H_ALE_HI:
          if (cnt == 4'h1)
          begin
            cnt <= lo_first ? SET_CYC : ALE_CYC;
            st <= lo_first ? MHB_H_SETUP : MHB_H_ALE_LO;
          end
          else
            cnt <= cnt - 4'h1;
        MHB_H_ALE_LO:
          if (cnt == 4'h1)
          begin
            cnt <= lo_first ? ALE_CYC : SET_CYC;
            st <= lo_first ? MHB_H_ALE_HI : MHB_H_SETUP;
          end
          else
            cnt <= cnt - 4'h1;
        MHB_H_SETUP:
          if (cnt == 4'h1)
          begin
            cnt <= ACT_CYC;
            st <= MHB_H_STROBE;
          end
          else
            cnt <= cnt - 4'h1;
        MHB_H_STROBE:
          if (cnt == 4'h1)
          begin
            if (!wr)
            begin
              rsp_rdata <= bus.ad_in;
              rsp_valid <= 1'b1;
            end
            cnt <= GAP_CYC;
            st <= MHB_H_GAP;
          end
          else
            cnt <= cnt - 4'h1;
        MHB_H_GAP:
          if (cnt == 4'h1)
            st <= MHB_H_IDLE;
          else
            cnt <= cnt - 4'h1;
        default:
          st <= MHB_H_IDLE;
      endcase
    end
  end
  assign req_ready = (st == MHB_H_IDLE);

  // latch phase order flips after every access so the far end sees both orders
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      lo_first <= 1'b0;
    else if (st == MHB_H_GAP && cnt == 4'h1)
      lo_first <= !lo_first;
  end

  // ----------------------------------------
  // pin drive, polarity from straps
  // ----------------------------------------
  logic busy;
  logic strobe_on;
  logic ale_phase;
  // with unqualified latch strobes select waits for the setup phase after the latches
  assign busy = (st == MHB_H_SETUP) || (st == MHB_H_STROBE) || (ale_phase && strap.ale_cs_qualify);
  assign strobe_on = (st == MHB_H_STROBE);
  assign ale_phase = (st == MHB_H_ALE_HI) || (st == MHB_H_ALE_LO);
  // select spans setup and strobe, plus the latch phases when straps qualify them, so it never moves during a strobe
  assign bus.chip_select = busy ~^ strap.cs_pol_high;
  assign bus.high_addr_latch_strobe = (st == MHB_H_ALE_HI) ~^ strap.ale_pol_high;
  assign bus.low_addr_latch_strobe = (st == MHB_H_ALE_LO) ~^ strap.ale_pol_high;
  always_comb
  begin
    if (strap.dir_enable_mode)
    begin
      bus.read_dir = (!wr) ~^ strap.rd_pol_high;
      bus.write_transfer_enable_strobe = strobe_on ~^ strap.wr_pol_high;
    end
    else
    begin
      bus.read_dir = (strobe_on & !wr) ~^ strap.rd_pol_high;
      bus.write_transfer_enable_strobe = (strobe_on & wr) ~^ strap.wr_pol_high;
    end
  end
  assign bus.ad_host_out = (st == MHB_H_ALE_HI || (st == MHB_H_SETUP && lo_first)) ? {8'h00, addr[15:8]} :
                           (ale_phase || st == MHB_H_SETUP) ? {8'h00, addr[7:0]} : wdata;
  assign bus.ad_host_oe = (ale_phase || st == MHB_H_SETUP) ? 16'h00FF :
                          (strobe_on && wr) ? 16'hFFFF : 16'h0000;
endmodule : mhb_host

// ==== verification/mhb_bus_checker.sv ====
// assertions on the host bus between the two ends
`timescale 1ns/10ps
module mhb_bus_checker (
  input wire logic clk,
  input wire logic rstn,
  input wire mhb_pkg::mhb_strap_t strap,
  input wire logic chip_select,
  input wire logic read_dir,
  input wire logic write_transfer_enable_strobe,
  input wire logic [15:0] ad_dev_oe,
  input wire logic read_start,
  input wire logic write_start,
  input wire mhb_pkg::mhb_cycle_t cycle_state
);
  logic cs_on;
  logic rd_on;
  logic wr_on;
  logic stb_on;
  logic dm;
  assign dm = strap.dir_enable_mode;
  assign cs_on = chip_select == strap.cs_pol_high;
  assign rd_on = read_dir == strap.rd_pol_high;
  assign wr_on = write_transfer_enable_strobe == strap.wr_pol_high;
  assign stb_on = dm ? wr_on : (rd_on | wr_on);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  cs_sep_hold_a: assert property (!dm && stb_on && $past(stb_on) |-> $stable(chip_select))
    else $error("select moved inside a strobe");
  cs_en_hold_a: assert property (dm && wr_on && $past(wr_on) |-> $stable(chip_select))
    else $error("select moved inside enable");
  rd_sep_start_a: assert property (!dm && $rose(rd_on) && cs_on |-> ##[0:2] read_start)
    else $error("read strobe started no read");
  wr_sep_start_a: assert property (!dm && $rose(wr_on) && cs_on |-> ##[0:2] write_start)
    else $error("write strobe started no write");
  rd_en_start_a: assert property (dm && $rose(wr_on) && cs_on && rd_on |-> ##[0:2] read_start)
    else $error("enable with read started no read");
  wr_en_start_a: assert property (dm && $rose(wr_on) && cs_on && !rd_on |-> ##[0:2] write_start)
    else $error("enable with write started no write");
  cycle_end_a: assert property ($fell(stb_on) |-> ##[0:2] cycle_state == mhb_pkg::MHB_IDLE_CYC)
    else $error("cycle outlived its strobe");
  nocs_start_a: assert property (read_start || write_start |-> cs_on)
    else $error("cycle started without select");
  nocs_drive_a: assert property (ad_dev_oe != 16'h0000 |-> cs_on || $past(cs_on))
    else $error("data driven without select");
  start_pol_a: assert property (read_start |-> dm ? (wr_on || $past(wr_on)) : (rd_on || $past(rd_on)))
    else $error("read start against strap polarity");
  wr_enter_a: assert property (write_start |=> cycle_state == mhb_pkg::MHB_WRITE_CYC)
    else $error("write start did not enter a write");
  rd_drive_a: assert property (cycle_state == mhb_pkg::MHB_READ_CYC && stb_on && cs_on |-> &ad_dev_oe)
    else $error("read data not driven during read strobe");
endmodule : mhb_bus_checker

// ==== verification/tb_mux_host_bus_cycle_framing.sv ====
// self-checking bench for both ends of the host bus
`timescale 1ns/10ps
`define CMP(g, e) compare(16'(g), 16'(e))
module tb_mux_host_bus_cycle_framing;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  mhb_pkg::mhb_strap_t strap = 6'h00;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [15:0] req_addr = 16'h0000;
  logic [15:0] req_wdata = 16'h0000;
  logic [15:0] read_data = 16'h0000;
  logic req_ready;
  logic [15:0] rsp_rdata;
  logic rsp_valid;
  logic [15:0] cycle_addr;
  logic [15:0] write_data;
  logic read_start;
  logic write_start;
  logic write_done;
  mhb_pkg::mhb_cycle_t cycle_state;
  logic select_violation;
  int fail_count = 0;
  int n_compared = 0;
  logic [5:0] straps [4] = '{6'h1E, 6'h01, 6'h3F, 6'h20};
  logic [15:0] a;
  always #5 clk = ~clk;
  mhb_bus_if i_mhb_bus_if ();
  mhb_host i_mhb_host (.clk(clk), .rstn(rstn), .bus(i_mhb_bus_if), .strap(strap), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid));
  mhb_device i_mhb_device (.clk(clk), .rstn(rstn), .bus(i_mhb_bus_if), .strap_in(strap),
    .read_data(read_data), .cycle_addr(cycle_addr), .write_data(write_data), .read_start(read_start),
    .write_start(write_start), .write_done(write_done), .cycle_state(cycle_state),
    .select_violation(select_violation));
  mhb_bus_checker i_mhb_bus_checker (.clk(clk), .rstn(rstn), .strap(strap),
    .chip_select(i_mhb_bus_if.chip_select), .read_dir(i_mhb_bus_if.read_dir),
    .write_transfer_enable_strobe(i_mhb_bus_if.write_transfer_enable_strobe),
    .ad_dev_oe(i_mhb_bus_if.ad_dev_oe), .read_start(read_start), .write_start(write_start),
    .cycle_state(cycle_state));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic compare(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // one host access; data is the write value or the value the device returns
  task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= addr;
    req_wdata <= data;
    read_data <= data;
    @(posedge clk);
    req_valid <= 1'b0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (!(wr ? write_done : rsp_valid) && n < 30);
    `CMP(n < 30, 1'b1);
    `CMP(cycle_addr, addr);
    `CMP(wr ? write_data : rsp_rdata, data);
    n = 0;
    while (req_ready !== 1'b1 && n < 30)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    `CMP(cycle_state, mhb_pkg::MHB_IDLE_CYC);
  endtask : access
  // ----------------------------------------
  // tests: every strap set, writes and back-to-back reads
  // ----------------------------------------
  initial
  begin
    for (int s = 0; s < 4; s++)
    begin
      @(posedge clk);
      strap <= straps[s];
      rstn <= 1'b0;
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      #1;
      `CMP(i_mhb_bus_if.chip_select, !strap.cs_pol_high);
      `CMP(i_mhb_bus_if.write_transfer_enable_strobe, !strap.wr_pol_high);
      a = 16'h3C00 + 16'(s * 16'h0111);
      access(1'b1, a, 16'hA55A ^ a);
      access(1'b0, a + 16'h0001, 16'h5AC3 ^ a);
      access(1'b0, a + 16'h0102, 16'hC35A ^ a);
      access(1'b1, a + 16'h0203, 16'h0FF0 ^ a);
      `CMP(select_violation, 1'b0);
      $display("strap set %0d done", s);
    end
    give_verdict();
  end
  initial
  begin
    repeat (3000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule : tb_mux_host_bus_cycle_framing
